// *** floppy_rate_fifo_input_regs.sv ***
// Rate, data port, fifo and digital input registers on a Wishbone slave
module floppy_rate_fifo_input_regs
  import floppy_rate_fifo_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sequencer side
  input wire phase_e phase,
  input wire logic exec_to_host,
  input wire logic core_in_valid,
  input wire logic [7:0] core_in_data,
  output logic core_in_ready_q,
  output logic core_out_valid_q,
  output logic [7:0] core_out_data_q,
  input wire logic core_out_ready,
  // Mode and pin
  input wire reg_mode_e reg_mode,
  input wire logic disk_changed_in,
  // Controls
  output logic [1:0] rate_sel_q,
  output logic [2:0] precomp_code_q,
  output logic low_power_q,
  output logic soft_reset_q,
  output logic dma_req_q,
  output logic irq_req_q
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;

  // Depth must cover the 4-bit threshold and wrap cleanly
  if (DEPTH < 16 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two of at least 16");
  end

  // Pin synchroniser
  logic dchg_s1_q, dchg_s2_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dchg_s1_q <= 1'b0;
      dchg_s2_q <= 1'b0;
    end else begin
      dchg_s1_q <= disk_changed_in;
      dchg_s2_q <= dchg_s1_q;
    end
  end

  // Bus decode
  logic acc, wr, rd, hit_rs, hit_ms, hit_dp, hit_di, hit_rc, hit_fc, srst;
  always_comb begin
    acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr = acc & wb_we_i;
    rd = acc & ~wb_we_i;
    hit_rs = wb_adr_i == OFF_RATE_SEL;
    hit_ms = wb_adr_i == OFF_MAIN_STATUS;
    hit_dp = wb_adr_i == OFF_DATA_PORT;
    hit_di = wb_adr_i == OFF_DIG_INPUT;
    hit_rc = wb_adr_i == OFF_RATE_CFG;
    hit_fc = wb_adr_i == OFF_FIFO_CTRL;
    srst = wr & hit_rs & wb_sel_i[0] & wb_dat_i[RS_SRST_BIT];
  end

  // Rate, precomp, power and fifo control state
  logic [2:0] pc_sel_q, pc_sel_d, precomp_code_d;
  logic [1:0] rate_sel_d;
  logic no_pre_q, no_pre_d, low_power_d;
  fifo_ctrl_s fc_q, fc_d;
  always_comb begin
    rate_sel_d = rate_sel_q;
    pc_sel_d = pc_sel_q;
    no_pre_d = no_pre_q;
    low_power_d = low_power_q;
    fc_d = fc_q;
    // A software reset write leaves rate and precomp fields alone and clears low power
    if (wr & hit_rs & wb_sel_i[0] & ~wb_dat_i[RS_SRST_BIT]) begin
      rate_sel_d = wb_dat_i[1:0];
      pc_sel_d = wb_dat_i[RS_PC_LSB +: 3];
      low_power_d = wb_dat_i[RS_LP_BIT];
    end
    if (wr & hit_rc & wb_sel_i[0]) begin
      rate_sel_d = wb_dat_i[1:0];
      if (reg_mode == MODE_C) begin
        no_pre_d = wb_dat_i[CFG_NO_PRECOMP_BIT_BIT];
      end
    end
    if (wr & hit_fc) begin
      if (wb_sel_i[0]) begin
        fc_d.en = wb_dat_i[FC_EN_BIT];
        fc_d.lock = wb_dat_i[FC_LOCK_BIT];
        fc_d.burst = wb_dat_i[FC_BURST_BIT];
        fc_d.rd_dis = wb_dat_i[FC_RDDIS_BIT];
        fc_d.wr_dis = wb_dat_i[FC_WRDIS_BIT];
        fc_d.dma_en = wb_dat_i[FC_DMA_BIT];
      end
      if (wb_sel_i[1]) begin
        fc_d.fifo_threshold = wb_dat_i[FC_TH_LSB +: 4];
      end
    end
    // Any data port or status access wakes the controller
    if (acc & (hit_dp | hit_ms)) begin
      low_power_d = 1'b0;
    end
    // Software reset keeps rate, precomp and stored bits
    if (srst) begin
      low_power_d = 1'b0;
      if (!fc_q.lock) begin
        fc_d.en = 1'b0;
        fc_d.fifo_threshold = 4'h0;
      end
    end
    if (pc_sel_d == PC_DEFAULT) begin
      precomp_code_d = (rate_sel_d == RATE_1M) ? PC_41_7NS : PC_125NS;
    end else begin
      precomp_code_d = pc_sel_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rate_sel_q <= RATE_SEL_RST[1:0];
      pc_sel_q <= RATE_SEL_RST[RS_PC_LSB +: 3];
      precomp_code_q <= PC_125NS;
      no_pre_q <= 1'b0;
      low_power_q <= RATE_SEL_RST[RS_LP_BIT];
      soft_reset_q <= 1'b0;
      fc_q <= '0;
    end else begin
      rate_sel_q <= rate_sel_d;
      pc_sel_q <= pc_sel_d;
      precomp_code_q <= precomp_code_d;
      no_pre_q <= no_pre_d;
      low_power_q <= low_power_d;
      soft_reset_q <= srst;
      fc_q <= fc_d;
    end
  end

  // Data path direction and fifo sizing per phase
  phase_e phase_q;
  logic d2h, exec, fifo_on, flush;
  logic [CNT_W-1:0] eff_depth, eff_th;
  always_comb begin
    exec = phase == PH_EXEC;
    d2h = (phase == PH_RESULT) | (exec & exec_to_host);
    fifo_on = exec & fc_q.en & ~(exec_to_host ? fc_q.rd_dis : fc_q.wr_dis);
    eff_depth = fifo_on ? CNT_W'(DEPTH) : CNT_W'(1);
    eff_th = fifo_on ? CNT_W'(fc_q.fifo_threshold) : '0;
    flush = (phase != phase_q) | srst;
  end

  // Fifo storage and pointers
  logic [7:0] mem [DEPTH];
  logic [PTR_W-1:0] wp_q, wp_d, rp_q, rp_d, rp_nx;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0] push_data, head_d;
  logic host_push, host_pop, core_push, core_pop, push, pop;
  logic in_ready_d, out_valid_d;
  always_comb begin
    host_push = wr & hit_dp & wb_sel_i[0] & ~d2h & (cnt_q < eff_depth)
                & ((phase == PH_CMD) | exec);
    host_pop = rd & hit_dp & d2h & (cnt_q != '0);
    core_push = core_in_valid & core_in_ready_q;
    core_pop = core_out_valid_q & core_out_ready;
    push = (host_push | core_push) & ~flush;
    pop = (host_pop | core_pop) & ~flush;
    push_data = host_push ? wb_dat_i[7:0] : core_in_data;
    rp_nx = rp_q + PTR_W'(1);
    if (flush) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end else begin
      wp_d = push ? wp_q + PTR_W'(1) : wp_q;
      rp_d = pop ? rp_nx : rp_q;
      cnt_d = cnt_q + CNT_W'(push) - CNT_W'(pop);
    end
    // Head byte as seen after this edge
    if (cnt_q == '0 || (cnt_q == CNT_W'(1) && pop)) begin
      head_d = push_data;
    end else if (pop) begin
      head_d = mem[rp_nx];
    end else begin
      head_d = mem[rp_q];
    end
    in_ready_d = d2h & (cnt_d < eff_depth);
    out_valid_d = ~d2h & (phase != PH_IDLE) & (cnt_d != '0);
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= PH_IDLE;
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      core_out_data_q <= 8'h00;
      core_in_ready_q <= 1'b0;
      core_out_valid_q <= 1'b0;
    end else begin
      phase_q <= phase;
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      core_out_data_q <= head_d;
      core_in_ready_q <= in_ready_d;
      core_out_valid_q <= out_valid_d;
    end
  end

  // Execution phase service request
  req_state_e req_q, req_d;
  logic [3:0] gap_q, gap_d;
  logic want, done, host_xfer;
  always_comb begin
    if (d2h) begin
      want = cnt_q >= eff_depth - eff_th;
      done = cnt_q == '0;
    end else begin
      want = cnt_q <= eff_th;
      done = cnt_q == eff_depth;
    end
    host_xfer = host_push | host_pop;
    req_d = req_q;
    gap_d = gap_q;
    unique case (req_q)
      REQ_IDLE: begin
        if (exec & want & ~flush) begin
          req_d = REQ_ON;
        end
      end
      REQ_ON: begin
        if (!exec || flush) begin
          req_d = REQ_IDLE;
        end else if (fc_q.burst) begin
          if (done || (host_xfer && cnt_d == (d2h ? '0 : eff_depth))) begin
            req_d = REQ_IDLE;
          end
        end else if (host_xfer) begin
          req_d = REQ_GAP;
          gap_d = GAP_LAST;
        end
      end
      REQ_GAP: begin
        if (!exec || flush) begin
          req_d = REQ_IDLE;
        end else if (gap_q == 4'h0) begin
          req_d = want ? REQ_ON : REQ_IDLE;
        end else begin
          gap_d = gap_q - 4'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_q <= REQ_IDLE;
      gap_q <= 4'h0;
      dma_req_q <= 1'b0;
      irq_req_q <= 1'b0;
    end else begin
      req_q <= req_d;
      gap_q <= gap_d;
      dma_req_q <= (req_d == REQ_ON) & fc_q.dma_en;
      irq_req_q <= (req_d == REQ_ON) & ~fc_q.dma_en;
    end
  end

  // Read data and acknowledge
  logic [7:0] main_status_reg, dig_in;
  logic [31:0] rdata;
  logic host_request_flag, high_density_flag;
  always_comb begin
    unique case (phase)
      PH_CMD: host_request_flag = cnt_q == '0;
      PH_RESULT: host_request_flag = cnt_q != '0;
      PH_EXEC: host_request_flag = ~fc_q.dma_en & irq_req_q;
      default: host_request_flag = 1'b0;
    endcase
    main_status_reg = {host_request_flag, d2h, exec & ~fc_q.dma_en, phase != PH_IDLE, 4'h0};
    high_density_flag = rate_sel_q[0] ^ rate_sel_q[1];
    // Disk changed passes through even in low power
    unique case (reg_mode)
      MODE_B: dig_in = {dchg_s2_q, 4'hF, rate_sel_q, high_density_flag};
      MODE_C: dig_in = {~dchg_s2_q, 3'h0, fc_q.dma_en, no_pre_q, rate_sel_q};
      default: dig_in = {dchg_s2_q, 7'h00};
    endcase
    rdata = 32'h0000_0000;
    if (rd) begin
      if (hit_ms) begin
        rdata = {24'h00_0000, main_status_reg};
      end else if (hit_dp && d2h) begin
        rdata = {24'h00_0000, core_out_data_q};
      end else if (hit_di) begin
        rdata = {24'h00_0000, dig_in};
      end else if (hit_fc) begin
        rdata = {20'h0_0000, fc_q.fifo_threshold, 2'h0, fc_q.dma_en, fc_q.wr_dis,
                 fc_q.rd_dis, fc_q.burst, fc_q.lock, fc_q.en};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= rdata;
    end
  end
endmodule

// *** floppy_rate_fifo_input_regs_test.sv ***
// Self-checking bench of the rate, data port and input registers
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module floppy_rate_fifo_input_regs_test
  import floppy_rate_fifo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0, resetn = 1'h0, wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
  logic exec_to_host = 1'h0, dchg = 1'h0, slow = 1'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, st = 32'h20;
  phase_e phase = PH_IDLE;
  reg_mode_e reg_mode = MODE_C;
  logic wb_ack_o, core_in_ready_q, core_out_valid_q, core_in_valid, core_out_ready;
  logic low_power_q, soft_reset_q, dma_req_q, irq_req_q;
  logic [7:0] core_out_data_q, core_in_data, b;
  logic [1:0] rate_sel_q, r;
  logic [2:0] precomp_code_q;
  logic [31:0] wb_dat_o, e;
  logic [31:0] expq[$];
  logic [7:0] bq[3];
  int err_total = 0, n_compared = 0, run = 0, gap = 0;
  always #25 clk = !clk;
  floppy_rate_fifo_input_regs #(.DEPTH(16)) i_dut (.clk(clk), .resetn(resetn),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'h3), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .phase(phase), .exec_to_host(exec_to_host), .core_in_valid(core_in_valid),
    .core_in_data(core_in_data), .core_in_ready_q(core_in_ready_q),
    .core_out_valid_q(core_out_valid_q), .core_out_data_q(core_out_data_q),
    .core_out_ready(core_out_ready), .reg_mode(reg_mode), .disk_changed_in(dchg),
    .rate_sel_q(rate_sel_q), .precomp_code_q(precomp_code_q), .low_power_q(low_power_q),
    .soft_reset_q(soft_reset_q), .dma_req_q(dma_req_q), .irq_req_q(irq_req_q));
  floppy_seq_model i_seq (.clk(clk), .core_in_ready_q(core_in_ready_q),
    .core_out_valid_q(core_out_valid_q), .core_out_data_q(core_out_data_q), .slow(slow),
    .core_in_valid(core_in_valid), .core_in_data(core_in_data),
    .core_out_ready(core_out_ready));
  // Random source
  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  // Wishbone classic cycle; a read notes its expected data
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    if (!w) expq.push_back(d);
    do @(posedge clk); while (wb_ack_o !== 1'h1);
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    wb_we <= 1'h0;
  endtask
  // Read data compared against the oldest note
  always @(posedge clk) begin
    if (wb_ack_o === 1'h1 && !wb_we) begin
      e = expq.pop_front();
      `CHK("read data", e, wb_dat_o)
    end
  end
  // Length of the last low stretch of the DMA request
  always @(posedge clk) begin
    if (dma_req_q === 1'h0) run <= run + 1;
    else begin
      if (run != 0) gap <= run;
      run <= 0;
    end
  end
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("Error watchdog expected end seen timeout");
    results();
  end
  initial begin
    b = 8'(xs());
    dchg <= b[0];
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    repeat (3) @(posedge clk);
    `CHK("rate", RATE_250K, rate_sel_q)
    `CHK("precomp", PC_125NS, precomp_code_q)
    bus(1'h0, OFF_DIG_INPUT, {24'h0, ~dchg, 7'h02});
    bus(1'h0, OFF_FIFO_CTRL, 32'h0);
    bus(1'h0, OFF_RATE_CFG, 32'h0);
    bus(1'h0, 8'h1C, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      r = 2'(i);
      bus(1'h1, OFF_RATE_SEL, {24'h0, 2'h1, 4'h0, r});
      `CHK("rate", r, rate_sel_q)
      `CHK("precomp", (r == RATE_1M) ? PC_41_7NS : PC_125NS, precomp_code_q)
      reg_mode <= MODE_B;
      bus(1'h0, OFF_DIG_INPUT, {24'h0, dchg, 4'hF, r, r == RATE_300K || r == RATE_250K});
      reg_mode <= MODE_A;
      bus(1'h0, OFF_DIG_INPUT, {24'h0, dchg, 7'h0});
      reg_mode <= MODE_C;
    end
    `CHK("low power", 1'h1, low_power_q)
    $display("rate test done");
    bus(1'h1, OFF_RATE_CFG, 32'h5);
    `CHK("rate", RATE_300K, rate_sel_q)
    bus(1'h1, OFF_FIFO_CTRL, 32'h0501);
    bus(1'h1, OFF_RATE_SEL, 32'h80);
    `CHK("soft reset", 1'h1, soft_reset_q)
    `CHK("low power", 1'h0, low_power_q)
    `CHK("rate", RATE_300K, rate_sel_q)
    bus(1'h0, OFF_DIG_INPUT, {24'h0, ~dchg, 5'h01, RATE_300K});
    bus(1'h0, OFF_FIFO_CTRL, 32'h0);
    bus(1'h1, OFF_FIFO_CTRL, 32'h0503);
    bus(1'h1, OFF_RATE_SEL, 32'h80);
    bus(1'h0, OFF_FIFO_CTRL, 32'h0503);
    $display("soft reset test done");
    phase <= PH_RESULT;
    b = 8'(xs());
    i_seq.push(b);
    bus(1'h0, OFF_MAIN_STATUS, 32'hD0);
    bus(1'h0, OFF_DATA_PORT, {24'h0, b});
    phase <= PH_IDLE;
    bus(1'h0, OFF_DATA_PORT, 32'h0);
    phase <= PH_CMD;
    slow <= 1'h1;
    b = 8'(xs());
    bus(1'h0, OFF_MAIN_STATUS, 32'h90);
    bus(1'h1, OFF_DATA_PORT, {24'h0, b});
    repeat (4) @(posedge clk);
    `CHK("command byte", b, i_seq.last_rx)
    $display("phase test done");
    bus(1'h1, OFF_FIFO_CTRL, 32'h0F21);
    phase <= PH_EXEC;
    exec_to_host <= 1'h1;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      bq[k] = 8'(xs());
      i_seq.push(bq[k]);
    end
    do @(posedge clk); while (dma_req_q !== 1'h1);
    bus(1'h0, OFF_DATA_PORT, {24'h0, bq[0]});
    do @(posedge clk); while (dma_req_q !== 1'h1);
    @(posedge clk);
    `CHK("request gap", GAP_CYC, gap)
    bus(1'h0, OFF_DATA_PORT, {24'h0, bq[1]});
    bus(1'h0, OFF_DATA_PORT, {24'h0, bq[2]});
    phase <= PH_IDLE;
    $display("fifo test done");
    // Burst write transfer served by interrupt request
    bus(1'h1, OFF_FIFO_CTRL, 32'h0005);
    phase <= PH_EXEC;
    exec_to_host <= 1'h0;
    do @(posedge clk); while (irq_req_q !== 1'h1);
    bus(1'h0, OFF_MAIN_STATUS, 32'hB0);
    for (int k = 0; k < 2; k++) begin
      bq[k] = 8'(xs());
      bus(1'h1, OFF_DATA_PORT, {24'h0, bq[k]});
      `CHK("burst request", 1'h1, irq_req_q)
    end
    repeat (4) @(posedge clk);
    `CHK("exec byte", bq[1], i_seq.last_rx)
    phase <= PH_IDLE;
    $display("burst test done");
    repeat (2) @(posedge clk);
    results();
  end
endmodule
bind floppy_rate_fifo_input_regs floppy_rate_fifo_properties i_props (.clk(clk),
  .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .phase(phase), .core_in_valid(core_in_valid),
  .core_in_ready_q(core_in_ready_q), .core_out_valid_q(core_out_valid_q),
  .core_out_data_q(core_out_data_q), .core_out_ready(core_out_ready),
  .rate_sel_q(rate_sel_q), .soft_reset_q(soft_reset_q), .dma_req_q(dma_req_q),
  .irq_req_q(irq_req_q));

// *** floppy_rate_fifo_pkg.sv ***
// Constants, types and field layout for the floppy rate, data port and input registers
// Functional notes
// - Default precomp: 41.7 ns at 1 Mb/s, 125.0 ns at other rates.
// - Rate bits survive software reset; hardware reset forces 250 kb/s code.
// - Rate code 11=1M, 00=500k/250k, 01=300k/150k, 10=250k/125k.
// - Only execution bytes use the 16-byte FIFO; other phases use one byte.
// - Locked FIFO stays enabled over software reset; hardware reset disables it.
// - FIFO serves DMA, interrupt or polled transfers in read/write/format/scan.
// - Burst mode holds the request until the whole burst has moved.
// - Non-burst mode drops the request 350 ns between transfers.
// - FIFO can be disabled separately for reads and for writes.
// - Hardware reset gives FIFO disabled with threshold zero.
// - Mode A input register drives D7 disk changed only, D6-D0 undriven; here D6-D0 read as zeros.
// - Mode B: D7 changed, D6-D3 ones, D2-D1 rate, D0 high density.
// - Mode C: D7 inverted changed, zeros, DMA enable, no-precomp, rate bits.
// - Disk changed bit may be invalid while powered down.
// - Software reset leaves the digital input register untouched.
// - Active rate is the latest write to either rate register.
// - Config register is write-only rate in D1-D0, hardware reset 250 kb/s.
// - Mode C stores config D2 without effect and shows it in input register.
// - Result bytes readable through data port only in result phase.
// - Hardware reset loads rate select register with 02 hex.
// - Direction flag reads 0 when device expects a write, 1 for a read.
package floppy_rate_fifo_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_RATE_SEL = 8'h00;
  localparam logic [7:0] OFF_MAIN_STATUS = 8'h04;
  localparam logic [7:0] OFF_DATA_PORT = 8'h08;
  localparam logic [7:0] OFF_DIG_INPUT = 8'h0C;
  localparam logic [7:0] OFF_RATE_CFG = 8'h10;
  localparam logic [7:0] OFF_FIFO_CTRL = 8'h14;
  // Rate select and config register fields
  localparam int RS_SRST_BIT = 7;
  localparam int RS_LP_BIT = 6;
  localparam int RS_PC_LSB = 2;
  localparam int CFG_NO_PRECOMP_BIT_BIT = 2;
  // Fifo control fields
  localparam int FC_EN_BIT = 0;
  localparam int FC_LOCK_BIT = 1;
  localparam int FC_BURST_BIT = 2;
  localparam int FC_RDDIS_BIT = 3;
  localparam int FC_WRDIS_BIT = 4;
  localparam int FC_DMA_BIT = 5;
  localparam int FC_TH_LSB = 8;
  // Reset values, rate codes and precomp codes
  localparam logic [7:0] RATE_SEL_RST = 8'h02;
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [2:0] PC_DEFAULT = 3'h0;
  localparam logic [2:0] PC_41_7NS = 3'h1;
  localparam logic [2:0] PC_125NS = 3'h3;
  localparam real PRECOMP_FAST_NS = 41.7;
  localparam real PRECOMP_SLOW_NS = 125.0;
  // Timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int GAP_NS = 350;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] GAP_LAST = 4'(GAP_CYC - 1);
  // Command phase reported by the sequencer
  typedef enum logic [1:0] {
    PH_IDLE = 2'h0, PH_CMD = 2'h1, PH_EXEC = 2'h2, PH_RESULT = 2'h3
  } phase_e;
  // Register layout mode
  typedef enum logic [1:0] {
    MODE_A = 2'h0, MODE_B = 2'h1, MODE_C = 2'h2
  } reg_mode_e;
  // Service request states
  typedef enum logic [2:0] {
    REQ_IDLE = 3'b001, REQ_ON = 3'b010, REQ_GAP = 3'b100
  } req_state_e;
  // Fifo configuration
  typedef struct packed {
    logic [3:0] fifo_threshold;
    logic dma_en;
    logic wr_dis;
    logic rd_dis;
    logic burst;
    logic lock;
    logic en;
  } fifo_ctrl_s;
endpackage

// *** floppy_rate_fifo_properties.sv ***
// Checker for bus timing, rate retention and service requests of the register block
module floppy_rate_fifo_properties
  import floppy_rate_fifo_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Sequencer side
  input wire phase_e phase,
  input wire logic core_in_valid,
  input wire logic core_in_ready_q,
  input wire logic core_out_valid_q,
  input wire logic [7:0] core_out_data_q,
  input wire logic core_out_ready,
  // Controls
  input wire logic [1:0] rate_sel_q,
  input wire logic soft_reset_q,
  input wire logic dma_req_q,
  input wire logic irq_req_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Request taken, and byte waiting while the phase holds
  sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_wait; core_out_valid_q && !core_out_ready && $stable(phase); endsequence
  property p_ack_lat; s_take |=> wb_ack_o; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
  property p_rate_src; $changed(rate_sel_q) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i); endproperty
  a_rate_src: assert property (p_rate_src) else $error("rate changed alone");
  property p_soft_pulse; soft_reset_q |=> !soft_reset_q; endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset long");
  property p_req_exec; dma_req_q || irq_req_q |-> $past(phase) == PH_EXEC; endproperty
  a_req_exec: assert property (p_req_exec) else $error("request outside exec");
  property p_one_req; !(dma_req_q && irq_req_q); endproperty
  a_one_req: assert property (p_one_req) else $error("both requests");
  property p_out_hold;
    s_wait |=> soft_reset_q || (core_out_valid_q && $stable(core_out_data_q));
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("byte lost");
  property p_in_single;
    phase != PH_EXEC && $stable(phase) && core_in_valid && core_in_ready_q
      |=> !core_in_ready_q || soft_reset_q;
  endproperty
  a_in_single: assert property (p_in_single) else $error("not single byte");
endmodule

// *** floppy_seq_model.sv ***
// Behavioural sequencer model pushing and taking bytes
module floppy_seq_model (
  // Clock
  input wire logic clk,
  // Handshakes
  input wire logic core_in_ready_q,
  input wire logic core_out_valid_q,
  input wire logic [7:0] core_out_data_q,
  input wire logic slow,
  output logic core_in_valid,
  output logic [7:0] core_in_data,
  output logic core_out_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog = 1'h0;
  logic [7:0] last_rx = 8'h00;
  initial core_in_valid = 1'h0;
  initial core_in_data = 8'h00;
  // Stalls every other cycle when slow
  assign core_out_ready = !slow || tog;
  always @(posedge clk) begin
    tog <= !tog;
    if (core_out_valid_q && core_out_ready) last_rx <= core_out_data_q;
  end
  // Push held until ready, then data line scrambled
  task automatic push(input logic [7:0] d);
    core_in_valid <= 1'h1;
    core_in_data <= d;
    do @(posedge clk); while (core_in_ready_q !== 1'h1);
    core_in_valid <= 1'h0;
    core_in_data <= ~d;
    @(posedge clk);
  endtask
endmodule
